// ### rtl/irq_vector_regs.vh
// Purpose: constants for the interrupt prioritisation and vectoring block
// Assumes: 16-bit vector addresses, levels 0..16, level 0 highest
// Notes:   vector of level n sits at trap vector minus 2*n, except level 14, which shares level 15's
`ifndef IRQ_VECTOR_REGS_VH
`define IRQ_VECTOR_REGS_VH

// --------------------------------------------------------------------
// priority levels
// --------------------------------------------------------------------
`define LVL_EXT_PIN     5'd1
`define LVL_LOCK        5'd2
`define LVL_T1_CH0      5'd3
`define LVL_T1_CH1      5'd4
`define LVL_T1_WRAP     5'd5
`define LVL_T2_CH0      5'd6
`define LVL_T2_WRAP     5'd8
`define LVL_SPI_RX      5'd9
`define LVL_SPI_TX      5'd10
`define LVL_SER_ERR     5'd11
`define LVL_COUNT       17

// --------------------------------------------------------------------
// vectors and reset values
// --------------------------------------------------------------------
`define VEC_RESET       16'hfffe
`define VEC_TRAP        16'hfffc
`define VEC_KBD_ADC     16'hffde
`define VEC_TIMEBASE    16'hffdc
`define PC_RESET        16'h0000
`define SP_RESET        16'h00ff
`define WRAP_VALUE      16'h0000
`define STACK_BYTES     3'd5

`endif

// ### rtl/irq_vector.v
// What this block does
// - pending interrupts are taken only at an instruction boundary
// - entry pushes PC, X, A, CCR; index high byte is not stacked
// - entry sets the global mask; a latched request is never preempted
// - at a boundary with mask clear, the highest pending level wins
// - a request pending after return-from-trap is taken before next instr
// - entry ends loading PC from the level's two-byte vector
// - level 0 highest: reset and trap; sources 1 to 16 in table order
// - the global mask blocks all sources but the software trap
// - software trap stacks PC, hardware entry stacks PC minus 1
// - a reached breakpoint forces a software trap on the level-0 vector
// - low external pin latches a level 1 request
// - any lock indication change sets the lock-change flag
// - timer wrap flag sets when counter returns to 0000 after modulo
// - timer channel capture or compare sets its channel event flag
// - second timer gives only channel 0 (level 6) and wrap (level 8)
// - SPI byte into receive register sets the receive-full flag
// - SPI byte into shift register sets the transmit-empty flag
// - mode fault: slave SS high mid-transfer, master SS low, if enabled
// - overflow flag when a new byte lands before the old one is read
// - overflow and mode fault share one error enable
// - serial overrun, noise, framing, parity each enabled, merged to one
//
// Purpose: flags, prioritisation and vectored entry sequencing
// Assumes: flag clears are one-cycle pulses from the owning peripherals
// Notes:   stack writes are one byte per cycle, five bytes per entry
`timescale 1ns/10ps
`include "irq_vector_regs.vh"

module irq_vector #(
    parameter LVL = `LVL_COUNT
) (
    // clock and reset
    input  wire        CLOCK,
    input  wire        RESET,
    // cpu sequencer handshake
    input  wire        INSTR_DONE,
    input  wire        RETURN_FROM_TRAP,
    input  wire        SOFTWARE_TRAP,
    input  wire        BREAK_HIT,
    input  wire        GLOBAL_MASK,
    input  wire [15:0] CPU_PC,
    input  wire [7:0]  CPU_X,
    input  wire [7:0]  CPU_A,
    input  wire [7:0]  CPU_CCR,
    // peripheral events
    input  wire        EXT_PIN_N,
    input  wire        EXT_PIN_REQ_MASK,
    input  wire        EXT_PIN_CLR,
    input  wire        PLL_LOCK,
    input  wire        LOCK_CHANGE_IRQ_EN,
    input  wire        LOCK_CHANGE_CLR,
    input  wire [1:0]  T1_CHAN_EVENT,
    input  wire [1:0]  T1_CHAN_EVENT_IRQ_EN,
    input  wire [1:0]  T1_CHAN_CLR,
    input  wire [15:0] T1_COUNT,
    input  wire [15:0] T1_MODULO,
    input  wire        T1_COUNTER_WRAP_IRQ_EN,
    input  wire        T1_WRAP_CLR,
    input  wire        T2_CHAN_EVENT,
    input  wire        T2_CHAN_EVENT_IRQ_EN,
    input  wire        T2_CHAN_CLR,
    input  wire [15:0] T2_COUNT,
    input  wire [15:0] T2_MODULO,
    input  wire        T2_COUNTER_WRAP_IRQ_EN,
    input  wire        T2_WRAP_CLR,
    // spi events
    input  wire        SPI_RX_LOAD,
    input  wire        SPI_TX_LOAD,
    input  wire        SPI_RX_READ,
    input  wire        SPI_TX_WRITE,
    input  wire        SPI_MASTER,
    input  wire        SPI_ACTIVE,
    input  wire        SPI_SS,
    input  wire        MODE_FAULT_DETECT_EN,
    input  wire        MODE_FAULT_CLR,
    input  wire        RX_OVERFLOW_CLR,
    input  wire        RX_FULL_IRQ_EN,
    input  wire        TX_EMPTY_IRQ_EN,
    input  wire        SERIAL_ERROR_IRQ_EN,
    // serial error flags kept by the serial unit
    input  wire [3:0]  SER_ERR_FLAGS,
    input  wire [3:0]  SER_ERR_EN,
    // remaining level requests, levels 12 to 16
    input  wire [4:0]  OTHER_LEVEL_REQ,
    // outputs to the cpu sequencer
    output reg         ENTRY_BUSY,
    output reg         SET_GLOBAL_MASK,
    output reg         STACK_WE,
    output reg  [7:0]  STACK_DATA,
    output reg         PC_LOAD,
    output reg  [15:0] VECTOR_ADDR,
    output reg  [4:0]  SERVICE_LEVEL,
    // status
    output reg  [16:1] LEVEL_STATUS_BIT,
    output reg  [7:0]  PERIPH_FLAGS
);

    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    localparam [2:0] S_IDLE  = 3'b001;
    localparam [2:0] S_STACK = 3'b010;
    localparam [2:0] S_VEC   = 3'b100;

    // vector address of a level: two bytes per level below the trap
    // vector; keyboard and converter levels share one vector
    function [15:0] level_vector;
        input [4:0] lvl;
        begin
            if (lvl == 5'd14 || lvl == 5'd15)
                level_vector = `VEC_KBD_ADC;
            else if (lvl == 5'd16)
                level_vector = `VEC_TIMEBASE;
            else
                level_vector = `VEC_TRAP - {10'h000, lvl, 1'b0};
        end
    endfunction

    // ----------------------------------------------------------------
    // peripheral flags: set wins over clear
    // ----------------------------------------------------------------
    reg        ext_pin_req_flag_r;
    reg        lock_change_flag_r;
    reg        lock_prev_r;
    reg [1:0]  t1_chan_event_flag_r;
    reg        t1_counter_wrap_flag_r;
    reg        t2_chan_event_flag_r;
    reg        t2_counter_wrap_flag_r;
    reg        t1_matched_r;
    reg        t2_matched_r;
    reg        rx_full_flag_r;
    reg        tx_empty_flag_r;
    reg        mode_fault_flag_r;
    reg        rx_overflow_flag_r;
    reg        ss_prev_r;

    wire t1_wrap = t1_matched_r && (T1_COUNT == `WRAP_VALUE);
    wire t2_wrap = t2_matched_r && (T2_COUNT == `WRAP_VALUE);
    wire slave_fault  = !SPI_MASTER && SPI_ACTIVE && SPI_SS && !ss_prev_r;
    wire master_fault = SPI_MASTER && !SPI_SS;
    wire mode_fault = MODE_FAULT_DETECT_EN
                      && (slave_fault || master_fault);
    wire overflow = SPI_RX_LOAD && rx_full_flag_r && !SPI_RX_READ;

    // each flag keeps its set above its clear
    always @(posedge CLOCK) begin
        if (RESET) begin
            ext_pin_req_flag_r     <= 1'b0;
            lock_change_flag_r     <= 1'b0;
            // edge detectors start at the pin level: no false edge
            lock_prev_r            <= PLL_LOCK;
            t1_chan_event_flag_r   <= 2'b00;
            t1_counter_wrap_flag_r <= 1'b0;
            t2_chan_event_flag_r   <= 1'b0;
            t2_counter_wrap_flag_r <= 1'b0;
            t1_matched_r           <= 1'b0;
            t2_matched_r           <= 1'b0;
            rx_full_flag_r         <= 1'b0;
            tx_empty_flag_r        <= 1'b1;
            mode_fault_flag_r      <= 1'b0;
            rx_overflow_flag_r     <= 1'b0;
            ss_prev_r              <= SPI_SS;
        end else begin
            lock_prev_r <= PLL_LOCK;
            ss_prev_r   <= SPI_SS;
            t1_matched_r <= (T1_COUNT == T1_MODULO);
            t2_matched_r <= (T2_COUNT == T2_MODULO);
            ext_pin_req_flag_r <= !EXT_PIN_N
                || (ext_pin_req_flag_r && !EXT_PIN_CLR);
            lock_change_flag_r <= (PLL_LOCK != lock_prev_r)
                || (lock_change_flag_r && !LOCK_CHANGE_CLR);
            t1_chan_event_flag_r <= T1_CHAN_EVENT
                | (t1_chan_event_flag_r & ~T1_CHAN_CLR);
            t2_chan_event_flag_r <= T2_CHAN_EVENT
                || (t2_chan_event_flag_r && !T2_CHAN_CLR);
            t1_counter_wrap_flag_r <= t1_wrap
                || (t1_counter_wrap_flag_r && !T1_WRAP_CLR);
            t2_counter_wrap_flag_r <= t2_wrap
                || (t2_counter_wrap_flag_r && !T2_WRAP_CLR);
            rx_full_flag_r <= SPI_RX_LOAD
                || (rx_full_flag_r && !SPI_RX_READ);
            tx_empty_flag_r <= SPI_TX_LOAD
                || (tx_empty_flag_r && !SPI_TX_WRITE);
            mode_fault_flag_r <= mode_fault
                || (mode_fault_flag_r && !MODE_FAULT_CLR);
            rx_overflow_flag_r <= overflow
                || (rx_overflow_flag_r && !RX_OVERFLOW_CLR);
        end
    end

    // ----------------------------------------------------------------
    // level requests: flag and enable, ored per level
    // ----------------------------------------------------------------
    reg [LVL-1:0] level_req;
    always @* begin
        level_req = {LVL{1'b0}};
        level_req[1]  = ext_pin_req_flag_r && !EXT_PIN_REQ_MASK;
        level_req[2]  = lock_change_flag_r && LOCK_CHANGE_IRQ_EN;
        level_req[3]  = t1_chan_event_flag_r[0]
                        && T1_CHAN_EVENT_IRQ_EN[0];
        level_req[4]  = t1_chan_event_flag_r[1]
                        && T1_CHAN_EVENT_IRQ_EN[1];
        level_req[5]  = t1_counter_wrap_flag_r
                        && T1_COUNTER_WRAP_IRQ_EN;
        level_req[6]  = t2_chan_event_flag_r
                        && T2_CHAN_EVENT_IRQ_EN;
        level_req[8]  = t2_counter_wrap_flag_r
                        && T2_COUNTER_WRAP_IRQ_EN;
        level_req[9]  = (rx_full_flag_r && RX_FULL_IRQ_EN)
                        || (SERIAL_ERROR_IRQ_EN
                        && (rx_overflow_flag_r || mode_fault_flag_r));
        level_req[10] = tx_empty_flag_r && TX_EMPTY_IRQ_EN;
        level_req[11] = |(SER_ERR_FLAGS & SER_ERR_EN);
        level_req[16:12] = OTHER_LEVEL_REQ;
    end

    // highest priority pending level: lowest index wins
    reg [4:0] win_lvl;
    reg       win_any;
    integer   i;
    always @* begin
        win_lvl = 5'd0;
        win_any = 1'b0;
        for (i = LVL - 1; i >= 1; i = i - 1) begin
            if (level_req[i]) begin
                win_lvl = i[4:0];
                win_any = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // entry sequencer
    // ----------------------------------------------------------------
    reg [2:0]  state_r;
    reg [2:0]  idx_r;
    reg [15:0] pc_save_r;
    reg [7:0]  x_save_r;
    reg [7:0]  a_save_r;
    reg [7:0]  ccr_save_r;
    reg [4:0]  lvl_r;

    // trap ignores the mask; hardware only at a boundary, mask clear
    wire trap_go = SOFTWARE_TRAP || BREAK_HIT;
    wire hw_go = (INSTR_DONE || RETURN_FROM_TRAP)
                 && !GLOBAL_MASK && win_any;

    // byte on the stack at each push step: pcl, pch, x, a, ccr
    reg [7:0] push_byte;
    always @* begin
        case (idx_r)
            3'd0:    push_byte = pc_save_r[7:0];
            3'd1:    push_byte = pc_save_r[15:8];
            3'd2:    push_byte = x_save_r;
            3'd3:    push_byte = a_save_r;
            default: push_byte = ccr_save_r;
        endcase
    end

    // latched request runs to completion, nothing preempts it
    always @(posedge CLOCK) begin
        if (RESET) begin
            state_r          <= S_IDLE;
            idx_r            <= 3'd0;
            pc_save_r        <= `PC_RESET;
            x_save_r         <= 8'h00;
            a_save_r         <= 8'h00;
            ccr_save_r       <= 8'h00;
            lvl_r            <= 5'd0;
            ENTRY_BUSY       <= 1'b0;
            SET_GLOBAL_MASK  <= 1'b0;
            STACK_WE         <= 1'b0;
            STACK_DATA       <= 8'h00;
            PC_LOAD          <= 1'b0;
            VECTOR_ADDR      <= `VEC_RESET;
            SERVICE_LEVEL    <= 5'd0;
            LEVEL_STATUS_BIT <= 16'h0000;
            PERIPH_FLAGS     <= 8'h00;
        end else begin
            LEVEL_STATUS_BIT <= level_req[16:1];
            PERIPH_FLAGS <= {rx_overflow_flag_r, mode_fault_flag_r,
                             tx_empty_flag_r, rx_full_flag_r,
                             t2_counter_wrap_flag_r,
                             t1_counter_wrap_flag_r,
                             lock_change_flag_r, ext_pin_req_flag_r};
            STACK_WE        <= 1'b0;
            PC_LOAD         <= 1'b0;
            SET_GLOBAL_MASK <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    if (trap_go || hw_go) begin
                        pc_save_r  <= trap_go ? CPU_PC
                                              : CPU_PC - 16'h0001;
                        x_save_r   <= CPU_X;
                        a_save_r   <= CPU_A;
                        ccr_save_r <= CPU_CCR;
                        lvl_r      <= trap_go ? 5'd0 : win_lvl;
                        idx_r      <= 3'd0;
                        ENTRY_BUSY <= 1'b1;
                        state_r    <= S_STACK;
                    end
                end
                S_STACK: begin
                    STACK_WE   <= 1'b1;
                    STACK_DATA <= push_byte;
                    idx_r      <= idx_r + 3'd1;
                    if (idx_r == `STACK_BYTES - 3'd1)
                        state_r <= S_VEC;
                end
                S_VEC: begin
                    SET_GLOBAL_MASK <= 1'b1;
                    PC_LOAD         <= 1'b1;
                    VECTOR_ADDR <= (lvl_r == 5'd0) ? `VEC_TRAP
                                                   : level_vector(lvl_r);
                    SERVICE_LEVEL   <= lvl_r;
                    ENTRY_BUSY      <= 1'b0;
                    state_r         <= S_IDLE;
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

endmodule // irq_vector

// ### testbench/irq_vector_asserts.sv
// Purpose: port-level checks for irq_vector
// Assumes: one clock, synchronous active-high reset
// Notes:   attached to every irq_vector by the bind below
`timescale 1ns/10ps
module irq_vector_chk (
    // clock and reset
    input wire        CLOCK,
    input wire        RESET,
    // stimulus seen
    input wire        EXT_PIN_N,
    input wire        EXT_PIN_REQ_MASK,
    input wire        PLL_LOCK,
    input wire        SPI_RX_LOAD,
    input wire        SPI_RX_READ,
    // block outputs
    input wire        ENTRY_BUSY,
    input wire        SET_GLOBAL_MASK,
    input wire        STACK_WE,
    input wire        PC_LOAD,
    input wire [15:0] VECTOR_ADDR,
    input wire [4:0]  SERVICE_LEVEL,
    input wire [16:1] LEVEL_STATUS_BIT,
    input wire [7:0]  PERIPH_FLAGS
);
    // ---------------------------------------------
    // entry sequence and flag setting
    // ---------------------------------------------
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RESET);
    // entry is six busy cycles closed by the vector load
    chk_entry_span: assert property (
        $rose(ENTRY_BUSY) |-> ENTRY_BUSY[*6] ##1 (PC_LOAD && !ENTRY_BUSY))
        else $error("entry length wrong");
    chk_stack_bytes: assert property (
        $rose(ENTRY_BUSY) |=> STACK_WE[*5] ##1 !STACK_WE)
        else $error("stack byte count wrong");
    chk_mask_at_load: assert property (PC_LOAD == SET_GLOBAL_MASK)
        else $error("mask set apart from vector load");
    chk_load_gap: assert property (PC_LOAD |=> !ENTRY_BUSY)
        else $error("entry overlaps the previous one");
    // levels up to 13 sit two bytes apart below the trap vector
    chk_vector_map: assert property (
        PC_LOAD && SERVICE_LEVEL != 5'h0 && SERVICE_LEVEL < 5'h0f
        |-> VECTOR_ADDR == (SERVICE_LEVEL == 5'h0e ? 16'hffde
            : 16'hfffc - {10'h0, SERVICE_LEVEL, 1'b0}))
        else $error("vector does not match level");
    chk_trap_vector: assert property (
        PC_LOAD && SERVICE_LEVEL == 5'h0 |-> VECTOR_ADDR == 16'hfffc)
        else $error("trap vector wrong");
    // flags reach the status port two edges after their event
    chk_ext_latch: assert property (!EXT_PIN_N |-> ##2 PERIPH_FLAGS[0])
        else $error("low pin not latched");
    chk_lock_edge: assert property (
        $changed(PLL_LOCK) |-> ##2 PERIPH_FLAGS[1])
        else $error("lock change not flagged");
    chk_rx_overflow: assert property (
        SPI_RX_LOAD && !SPI_RX_READ ##1 PERIPH_FLAGS[4]
        |-> ##1 PERIPH_FLAGS[7])
        else $error("overflow not flagged");
    chk_status_follow: assert property (
        PERIPH_FLAGS[0] && !$past(EXT_PIN_REQ_MASK) |-> LEVEL_STATUS_BIT[1])
        else $error("level 1 status missing");
endmodule // irq_vector_chk
bind irq_vector irq_vector_chk chk (.*);

// ### testbench/cpu_seq_model.sv
// Purpose: behavioural cpu sequencer facing irq_vector
// Assumes: a boundary every fourth cycle while run is high
// Notes:   mask follows the block's set pulse and return from trap
`timescale 1ns/10ps
module cpu_seq_model (
    // clock and reset
    input wire  CLOCK,
    input wire  RESET,
    // bench controls
    input wire  run,
    input wire  return_from_trap,
    // from the block
    input wire  set_mask,
    input wire  busy,
    // to the block
    output reg  instr_done = 1'b0,
    output reg  ret_trap = 1'b0,
    output reg  mask = 1'b0
);
    reg [1:0] gap_r = 2'h0;
    // no boundary while context is stacked, so nothing is cut short
    always @(posedge CLOCK) begin
        gap_r      <= RESET ? 2'h0 : gap_r + 2'h1;
        instr_done <= !RESET && run && gap_r == 2'h3
                      && !busy && !set_mask;
        ret_trap   <= !RESET && return_from_trap;
        if (RESET || return_from_trap)
            mask <= 1'b0;
        else if (set_mask)
            mask <= 1'b1;
    end
endmodule // cpu_seq_model

// ### testbench/prioritized_interrupt_vectoring_tb_top.sv
// Purpose: directed bench for irq_vector
// Assumes: cpu_seq_model gives boundaries and the global mask
// Notes:   the bench clears flags itself, as a peripheral would
`timescale 1ns/10ps
module prioritized_interrupt_vectoring_tb_top;
    // ---------------------------------------------
    // stimulus, wiring and helpers
    // ---------------------------------------------
    reg CLOCK = 1'b0, RESET = 1'b1, go_run = 1'b0, go_rti = 1'b0;
    reg SOFTWARE_TRAP = 1'b0, BREAK_HIT = 1'b0, EXT_PIN_N = 1'b1;
    reg EXT_PIN_REQ_MASK = 1'b0, EXT_PIN_CLR = 1'b0, PLL_LOCK = 1'b0;
    reg LOCK_CHANGE_IRQ_EN = 1'b1, LOCK_CHANGE_CLR = 1'b0, T1_WRAP_CLR = 1'b0;
    reg T1_COUNTER_WRAP_IRQ_EN = 1'b1, T2_CHAN_EVENT = 1'b0;
    reg T2_WRAP_CLR = 1'b0;
    reg T2_CHAN_EVENT_IRQ_EN = 1'b1, T2_CHAN_CLR = 1'b0, SPI_TX_LOAD = 1'b0;
    reg T2_COUNTER_WRAP_IRQ_EN = 1'b1, SPI_RX_LOAD = 1'b0, SPI_RX_READ = 1'b0;
    reg SPI_TX_WRITE = 1'b0, SPI_MASTER = 1'b0, SPI_ACTIVE = 1'b0;
    reg SPI_SS = 1'b1, MODE_FAULT_CLR = 1'b0, MODE_FAULT_DETECT_EN = 1'b0;
    reg RX_FULL_IRQ_EN = 1'b0, RX_OVERFLOW_CLR = 1'b0, TX_EMPTY_IRQ_EN = 1'b0;
    reg SERIAL_ERROR_IRQ_EN = 1'b1;
    reg  [1:0]  T1_CHAN_EVENT = 2'h0, T1_CHAN_EVENT_IRQ_EN = 2'h3;
    reg  [1:0]  T1_CHAN_CLR = 2'h0;
    reg  [15:0] T1_COUNT = 16'h0, T1_MODULO = 16'h3, CPU_PC = 16'h1234;
    reg  [15:0] T2_COUNT = 16'h0, T2_MODULO = 16'hffff;
    reg  [7:0]  CPU_X = 8'h5a, CPU_A = 8'ha5, CPU_CCR = 8'h60;
    reg  [3:0]  SER_ERR_FLAGS = 4'h0, SER_ERR_EN = 4'h4;
    reg  [4:0]  OTHER_LEVEL_REQ = 5'h0;
    reg  [39:0] stk = 40'h0;
    wire        INSTR_DONE, RETURN_FROM_TRAP, GLOBAL_MASK, ENTRY_BUSY;
    wire        SET_GLOBAL_MASK, STACK_WE, PC_LOAD;
    wire [7:0]  STACK_DATA, PERIPH_FLAGS;
    wire [15:0] VECTOR_ADDR;
    wire [4:0]  SERVICE_LEVEL;
    wire [16:1] LEVEL_STATUS_BIT;
    integer     n_mismatch = 0, total_checks = 0;
    irq_vector uut (.*);
    cpu_seq_model cpu (.CLOCK, .RESET, .run (go_run), .return_from_trap (go_rti),
        .set_mask (SET_GLOBAL_MASK), .busy (ENTRY_BUSY),
        .instr_done (INSTR_DONE), .ret_trap (RETURN_FROM_TRAP),
        .mask (GLOBAL_MASK));
    // clock and stacked-byte capture, first byte ends up on top
    always #5 CLOCK = ~CLOCK;
    always @(posedge CLOCK) if (STACK_WE) stk <= {stk[31:0], STACK_DATA};
    task chk(input [39:0] got, input [39:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // bounded wait for the vector load, then vector and stack compared
    task wait_load(input [15:0] vec, input [39:0] bytes, input [4:0] lvl);
        integer n;
        begin
            n = 0;
            #1;
            while (PC_LOAD !== 1'b1 && n < 40) begin
                @(posedge CLOCK);
                #1;
                n = n + 1;
            end
            chk(PC_LOAD, 1'b1);
            chk(VECTOR_ADDR, vec);
            chk(stk, bytes);
            chk(SERVICE_LEVEL, lvl);
            @(posedge CLOCK);
        end
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", total_checks, n_mismatch);
            if (n_mismatch == 0 && total_checks > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    // hang guard, far above the under one hundred cycles the run needs
    initial begin
        repeat (3000) @(posedge CLOCK);
        n_mismatch = n_mismatch + 1;
        close_out;
    end
    // main sequence; steps of one or more cycles each
    initial begin
        repeat (8) @(posedge CLOCK);
        RESET <= 1'b0;
        repeat (2) @(posedge CLOCK);
        #1;
        chk(VECTOR_ADDR, 16'hfffe);
        chk(PERIPH_FLAGS, 8'h20);
        @(posedge CLOCK);
        T1_CHAN_EVENT <= 2'h1;
        T2_CHAN_EVENT <= 1'b1;
        @(posedge CLOCK);
        T1_CHAN_EVENT <= 2'h0;
        T2_CHAN_EVENT <= 1'b0;
        go_run <= 1'b1;
        wait_load(16'hfff6, 40'h33125aa560, 5'd3);
        T1_CHAN_CLR <= 2'h1;
        go_rti <= 1'b1;
        @(posedge CLOCK);
        T1_CHAN_CLR <= 2'h0;
        go_rti <= 1'b0;
        wait_load(16'hfff0, 40'h33125aa560, 5'd6);
        T2_CHAN_CLR <= 1'b1;
        SOFTWARE_TRAP <= 1'b1;
        @(posedge CLOCK);
        T2_CHAN_CLR <= 1'b0;
        SOFTWARE_TRAP <= 1'b0;
        wait_load(16'hfffc, 40'h34125aa560, 5'd0);
        BREAK_HIT <= 1'b1;
        @(posedge CLOCK);
        BREAK_HIT <= 1'b0;
        wait_load(16'hfffc, 40'h34125aa560, 5'd0);
        EXT_PIN_N <= 1'b0;
        PLL_LOCK <= 1'b1;
        T1_COUNT <= 16'h3;
        SPI_RX_LOAD <= 1'b1;
        SPI_TX_WRITE <= 1'b1;
        @(posedge CLOCK);
        EXT_PIN_N <= 1'b1;
        T1_COUNT <= 16'h0;
        SPI_TX_WRITE <= 1'b0;
        LOCK_CHANGE_CLR <= 1'b1;
        @(posedge CLOCK);
        LOCK_CHANGE_CLR <= 1'b0;
        PLL_LOCK <= 1'b0;
        SPI_RX_LOAD <= 1'b0;
        MODE_FAULT_DETECT_EN <= 1'b1;
        SPI_MASTER <= 1'b1;
        SPI_SS <= 1'b0;
        // flags show on the port one edge after they set
        #1;
        chk(PERIPH_FLAGS, 8'h13);
        @(posedge CLOCK);
        SPI_TX_LOAD <= 1'b1;
        SER_ERR_FLAGS <= 4'h6;
        @(posedge CLOCK);
        SPI_TX_LOAD <= 1'b0;
        repeat (2) @(posedge CLOCK);
        #1;
        chk(PERIPH_FLAGS, 8'hf7);
        chk(LEVEL_STATUS_BIT, 16'h0513);
        @(posedge CLOCK);
        SERIAL_ERROR_IRQ_EN <= 1'b0;
        repeat (2) @(posedge CLOCK);
        #1;
        chk(LEVEL_STATUS_BIT, 16'h0413);
        @(posedge CLOCK);
        go_rti <= 1'b1;
        @(posedge CLOCK);
        go_rti <= 1'b0;
        wait_load(16'hfffa, 40'h33125aa560, 5'd1);
        // slave fault on a rising select, second timer wrap
        SPI_MASTER <= 1'b0;
        SPI_ACTIVE <= 1'b1;
        MODE_FAULT_CLR <= 1'b1;
        T2_COUNT <= 16'hffff;
        @(posedge CLOCK);
        MODE_FAULT_CLR <= 1'b0;
        T2_COUNT <= 16'h0000;
        @(posedge CLOCK);
        SPI_SS <= 1'b1;
        #1;
        chk(PERIPH_FLAGS[6], 1'b0);
        repeat (2) @(posedge CLOCK);
        #1;
        chk(PERIPH_FLAGS[6], 1'b1);
        chk(PERIPH_FLAGS[3], 1'b1);
        chk(LEVEL_STATUS_BIT[8], 1'b1);
        close_out;
    end
endmodule // prioritized_interrupt_vectoring_tb_top
